// ---- core/wtsc_state_control.v ----
`timescale 1ns/100ps
`include "wtsc_consts.vh"

module wtsc_state_control #(
  parameter [31:0] LOCK_LIMIT_CYC = `WTSC_LOCK_CYC,
  parameter [31:0] FAST_LIMIT_CYC = `WTSC_FAST_CYC
) (
  input wire clk,
  input wire resetn,
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [3:0] avs_byteenable,
  input wire [31:0] avs_writedata,
  output wire [31:0] avs_readdata,
  output wire avs_waitrequest,
  input wire op_select_hi,
  input wire op_select_lo,
  input wire phase_step_correct_enable,
  input wire quick_acquire_in,
  input wire ref_invalid_in,
  input wire dpll_lock_in,
  output wire frame_mark_31ns_low,
  output wire frame_mark_61ns_low,
  output wire frame_mark_122ns_high,
  output wire frame_mark_244ns_low,
  output wire receive_sync_pulse_out,
  output wire transmit_sync_pulse_out,
  output wire normal_status_out,
  output wire holdover_status_out,
  output wire freerun_status_out,
  output wire lock_status_out,
  output wire phase_step_correct_on
);

  // one-hot operating states
  localparam [3:0] state_normal = 4'h1;
  localparam [3:0] state_auto_holdover = 4'h2;
  localparam [3:0] state_manual_holdover = 4'h4;
  localparam [3:0] state_freerun = 4'h8;

  // frame length in cycles, kept as an integer for the arithmetic
  localparam integer frame_len = `WTSC_FRAME_CYC;
  // last count of the 8 kHz frame, cut to the counter width on purpose
  localparam integer frame_last_i = frame_len - 1;
  localparam [11:0] frame_last = frame_last_i[11:0];
  // marker polarity table
  localparam [5:0] mark_pol = `WTSC_MARK_POL;

  // pin synchronisers, two stages each
  reg [5:0] sync1_reg;
  reg [5:0] sync2_reg;
  wire [5:0] pins_raw;
  // synchronised pin levels
  wire [1:0] sel_s;
  wire tie_pin_s;
  wire quick_s;
  wire ref_bad_s;
  wire lock_s;

  // frame counter shared by every marker
  reg [11:0] cnt_reg;
  wire frame_tick;
  // marker levels before they take their output names
  wire [5:0] mark_w;

  // operating state
  reg [3:0] state_reg;
  reg [3:0] state_next;
  reg tie_reg;
  reg normal_reg;
  reg hold_reg;
  reg free_reg;
  reg lock_reg;
  // counts every mode change, wraps silently
  reg [15:0] changes_reg;

  // lock supervision
  reg [31:0] wait_cnt_reg;
  wire [31:0] wait_limit;
  wire watching;
  reg timeout_reg;

  // bus slave
  reg [1:0] ctrl_reg;
  reg wait_reg;
  reg [31:0] rdata_reg;
  reg [31:0] rd_mux;
  wire bus_req;
  wire bus_done;
  wire wr_ctrl;
  wire wr_status;

  // this order fixes the bit order of both synchroniser stages
  assign pins_raw = {dpll_lock_in, ref_invalid_in, quick_acquire_in,
                     phase_step_correct_enable, op_select_hi, op_select_lo};

  // pins are asynchronous to clk, so only stage two is read
  // select resets to 11, the keep code: zeros would decode as normal
  // and the first frame tick after reset would leave freerun unasked
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sync1_reg <= 6'h03;
      sync2_reg <= 6'h03;
    end else begin
      sync1_reg <= pins_raw;
      sync2_reg <= sync1_reg;
    end
  end

  assign sel_s = sync2_reg[1:0];
  assign tie_pin_s = sync2_reg[2];
  assign quick_s = sync2_reg[3];
  assign ref_bad_s = sync2_reg[4];
  assign lock_s = sync2_reg[5];

  // frame counter, held at zero while markers are stopped
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_reg <= 12'h000;
    end else if (!ctrl_reg[`WTSC_CTRL_RUN]) begin
      // stopping clears the count, so a restart opens a fresh frame
      cnt_reg <= 12'h000;
    end else if (cnt_reg == frame_last) begin
      // wrap every 125 us, one common frame boundary
      cnt_reg <= 12'h000;
    end else begin
      cnt_reg <= cnt_reg + 12'h001;
    end
  end

  // count zero is the edge where the 122 ns marker rises
  // gated by run, as a stopped counter sits at zero for good
  assign frame_tick = ctrl_reg[`WTSC_CTRL_RUN] && (cnt_reg == 12'h000);

  // one marker per entry, width and polarity from the tables
  genvar i;
  generate
    for (i = 0; i < 6; i = i + 1) begin : g_mark
      // width in cycles for this marker
      localparam integer width_i = (i == 0) ? `WTSC_M31_CYC :
                                   (i == 1) ? `WTSC_M61_CYC :
                                   (i == 2) ? `WTSC_M122_CYC :
                                   (i == 3) ? `WTSC_M244_CYC :
                                   `WTSC_M488_CYC;
      // cut to the counter width on purpose, widths are far below it
      localparam [11:0] width = width_i[11:0];
      reg m_reg;
      // active from the frame boundary for width cycles
      always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          m_reg <= ~mark_pol[i];
        end else if (ctrl_reg[`WTSC_CTRL_RUN] && (cnt_reg < width)) begin
          m_reg <= mark_pol[i];
        end else begin
          m_reg <= ~mark_pol[i];
        end
      end
      assign mark_w[i] = m_reg;
    end
  endgenerate

  // next state, looked at only on a frame tick
  always @* begin
    state_next = state_reg;
    case (state_reg)
      state_normal: begin
        if (sel_s == `WTSC_SEL_HOLD) begin
          state_next = state_manual_holdover;
        end else if (sel_s == `WTSC_SEL_FREE) begin
          state_next = state_freerun;
        end else if (sel_s == `WTSC_SEL_NORMAL && ref_bad_s) begin
          // detector, not pins, leaves normal
          state_next = state_auto_holdover;
        end
      end
      state_auto_holdover: begin
        if (sel_s == `WTSC_SEL_HOLD) begin
          state_next = state_manual_holdover;
        end else if (sel_s == `WTSC_SEL_FREE) begin
          state_next = state_freerun;
        end else if (sel_s == `WTSC_SEL_NORMAL && !ref_bad_s) begin
          // reference back in range
          state_next = state_normal;
        end
      end
      state_manual_holdover: begin
        // pin driven moves
        if (sel_s == `WTSC_SEL_NORMAL) begin
          state_next = state_normal;
        end else if (sel_s == `WTSC_SEL_FREE) begin
          state_next = state_freerun;
        end
      end
      state_freerun: begin
        // freerun leaves only by the select pins
        if (sel_s == `WTSC_SEL_NORMAL) begin
          state_next = state_normal;
        end else if (sel_s == `WTSC_SEL_HOLD) begin
          state_next = state_manual_holdover;
        end
      end
      // illegal code: park in freerun, the safe source
      default: state_next = state_freerun;
    endcase
    // code 11 matches no branch, so the mode stays
  end

  // state and correction gate, updated on the frame tick only
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      // freerun is the safe source until the pins are seen
      state_reg <= state_freerun;
      tie_reg <= 1'b0;
      changes_reg <= 16'h0000;
    end else if (frame_tick) begin
      state_reg <= state_next;
      if (state_next != state_reg) begin
        // count the change for software
        changes_reg <= changes_reg + 16'h0001;
        if ((state_next == state_normal) &&
            (state_reg == state_auto_holdover ||
             state_reg == state_manual_holdover)) begin
          // return to normal follows the enable pin
          tie_reg <= tie_pin_s;
        end else begin
          // any other change drops correction
          tie_reg <= 1'b0;
        end
      end
    end
  end

  // status indicators, one cycle behind the state
  // registering keeps the pins glitch free at one cycle of lag
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      normal_reg <= 1'b0;
      hold_reg <= 1'b0;
      free_reg <= 1'b0;
      lock_reg <= 1'b0;
    end else begin
      normal_reg <= state_reg[0];
      hold_reg <= state_reg[1] | state_reg[2];
      free_reg <= state_reg[3];
      // lock only means something while tracking
      lock_reg <= lock_s & state_reg[0];
    end
  end

  // lock supervision: flag a normal stretch that never locks
  // limit shrinks with quick acquire
  assign wait_limit = quick_s ? FAST_LIMIT_CYC : LOCK_LIMIT_CYC;
  assign watching = ctrl_reg[`WTSC_CTRL_WATCH] && state_reg[0] && !lock_s;

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wait_cnt_reg <= 32'h00000000;
    end else if (!watching) begin
      wait_cnt_reg <= 32'h00000000;
    end else if (wait_cnt_reg < wait_limit) begin
      // stop at the limit so the count cannot wrap and re-arm
      wait_cnt_reg <= wait_cnt_reg + 32'h00000001;
    end
  end

  // sticky timeout, set beats a write-one clear
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      timeout_reg <= 1'b0;
    end else if (watching && wait_cnt_reg >= wait_limit) begin
      timeout_reg <= 1'b1;
    end else if (wr_status && avs_writedata[`WTSC_STAT_TIMEOUT]) begin
      // write one clears, writing zero leaves the flag
      timeout_reg <= 1'b0;
    end
  end

  // avalon slave, one wait state on every access
  // a request is a level, taken while waitrequest is high
  assign bus_req = avs_read | avs_write;
  assign bus_done = bus_req & ~wait_reg;
  // limitation: only byte lane 0 counts, all writable fields sit there
  assign wr_ctrl = bus_done & avs_write & avs_byteenable[0] &
                   (avs_address == `WTSC_ADDR_CTRL);
  assign wr_status = bus_done & avs_write & avs_byteenable[0] &
                     (avs_address == `WTSC_ADDR_STATUS);

  // read mux; unmapped offsets read zero
  always @* begin
    rd_mux = 32'h00000000;
    case (avs_address)
      `WTSC_ADDR_CTRL: rd_mux = {30'h00000000, ctrl_reg};
      `WTSC_ADDR_STATUS: rd_mux = {22'h000000, sel_s, quick_s,
                                   timeout_reg, lock_reg, tie_reg,
                                   state_reg};
      `WTSC_ADDR_CHANGES: rd_mux = {16'h0000, changes_reg};
      default: rd_mux = 32'h00000000;
    endcase
  end

  // waitrequest drops for the completing cycle only
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wait_reg <= 1'b1;
      rdata_reg <= 32'h00000000;
    end else if (bus_req && wait_reg) begin
      wait_reg <= 1'b0;
      // captured on take, so it stands through the answer cycle
      rdata_reg <= rd_mux;
    end else begin
      wait_reg <= 1'b1;
    end
  end

  // control bits: marker run and lock watch
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      // both bits come up set, markers run from reset
      ctrl_reg <= `WTSC_CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_reg <= avs_writedata[1:0];
    end
  end

  // outputs, each straight from a flip-flop
  assign frame_mark_31ns_low = mark_w[0];
  assign frame_mark_61ns_low = mark_w[1];
  assign frame_mark_122ns_high = mark_w[2];
  assign frame_mark_244ns_low = mark_w[3];
  assign receive_sync_pulse_out = mark_w[4];
  assign transmit_sync_pulse_out = mark_w[5];
  // clk is the loop output, so markers track the reference
  assign normal_status_out = normal_reg;
  assign holdover_status_out = hold_reg;
  assign freerun_status_out = free_reg;
  assign lock_status_out = lock_reg;
  assign phase_step_correct_on = tie_reg;
  assign avs_readdata = rdata_reg;
  assign avs_waitrequest = wait_reg;

endmodule

// ---- core/wtsc_consts.vh ----
`ifndef WTSC_CONSTS_VH
`define WTSC_CONSTS_VH
// Contract
// - 31 ns low frame marker at 8 kHz
// - 61 ns low frame marker at 8 kHz
// - 122 ns high frame marker at 8 kHz
// - 244 ns low frame marker at 8 kHz
// - receive and transmit 488 ns high syncs
// - select pins: normal, holdover, freerun, reserved
// - state changes only on 122 ns marker rise
// - normal drops to auto-holdover on bad reference
// - auto-holdover returns to normal when reference good
// - normal/auto moves by detector, others by pins
// - any mode change disables phase-step correction; the code turns it on from holdover into normal when the enable pin is high
// - holdover into normal follows correction-enable pin
// - lock within 30 seconds from reset; the code times it only while in normal mode and unlocked, from entry to normal
// - normal status high in normal mode
// - quick acquire locks within 500 ms
// - normal mode outputs follow the reference
// - holdover status high in holdover
// - freerun status high in freerun
// - lock status high while frequency locked; the code shows it in normal mode only

// clock and frame timing
`define WTSC_CLK_MHZ 25
`define WTSC_FRAME_NS 125000
`define WTSC_FRAME_CYC ((`WTSC_FRAME_NS * `WTSC_CLK_MHZ) / 1000)
// marker widths, least times rounded up to whole cycles
`define WTSC_M31_NS 31
`define WTSC_M61_NS 61
`define WTSC_M122_NS 122
`define WTSC_M244_NS 244
`define WTSC_M488_NS 488
`define WTSC_M31_CYC ((`WTSC_M31_NS * `WTSC_CLK_MHZ + 999) / 1000)
`define WTSC_M61_CYC ((`WTSC_M61_NS * `WTSC_CLK_MHZ + 999) / 1000)
`define WTSC_M122_CYC ((`WTSC_M122_NS * `WTSC_CLK_MHZ + 999) / 1000)
`define WTSC_M244_CYC ((`WTSC_M244_NS * `WTSC_CLK_MHZ + 999) / 1000)
`define WTSC_M488_CYC ((`WTSC_M488_NS * `WTSC_CLK_MHZ + 999) / 1000)
// marker polarity, bit set means active high
`define WTSC_MARK_POL 6'h34
// lock supervision limits
`define WTSC_LOCK_S 30
`define WTSC_FAST_MS 500
`define WTSC_LOCK_CYC (`WTSC_LOCK_S * `WTSC_CLK_MHZ * 1000000)
`define WTSC_FAST_CYC (`WTSC_FAST_MS * `WTSC_CLK_MHZ * 1000)
// select pin codes
`define WTSC_SEL_NORMAL 2'h0
`define WTSC_SEL_HOLD 2'h1
`define WTSC_SEL_FREE 2'h2
// register byte offsets and the control reset value
`define WTSC_ADDR_CTRL 4'h0
`define WTSC_ADDR_STATUS 4'h4
`define WTSC_ADDR_CHANGES 4'h8
`define WTSC_CTRL_RESET 2'h3
// field positions
`define WTSC_CTRL_RUN 0
`define WTSC_CTRL_WATCH 1
`define WTSC_STAT_TIMEOUT 6
`endif

// ---- tb/wtsc_properties.sv ----
`timescale 1ns/100ps
// watches markers, status pins and correction enable of the state control
module wtsc_properties (
  input wire clk,
  input wire resetn,
  input wire frame_mark_31ns_low,
  input wire frame_mark_61ns_low,
  input wire frame_mark_122ns_high,
  input wire frame_mark_244ns_low,
  input wire receive_sync_pulse_out,
  input wire transmit_sync_pulse_out,
  input wire normal_status_out,
  input wire holdover_status_out,
  input wire freerun_status_out,
  input wire lock_status_out,
  input wire phase_step_correct_on
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // widths in whole cycles at 25 MHz
  a_mark31_width: assert property ($fell(frame_mark_31ns_low) |=> frame_mark_31ns_low)
    else $error("31 ns marker width wrong");
  a_mark61_width: assert property ($fell(frame_mark_61ns_low) |=>
    !frame_mark_61ns_low ##1 frame_mark_61ns_low)
    else $error("61 ns marker width wrong");
  a_mark122_width: assert property ($rose(frame_mark_122ns_high) |=>
    frame_mark_122ns_high [*3] ##1 !frame_mark_122ns_high)
    else $error("122 ns marker width wrong");
  a_mark244_width: assert property ($fell(frame_mark_244ns_low) |=>
    !frame_mark_244ns_low [*6] ##1 frame_mark_244ns_low)
    else $error("244 ns marker width wrong");
  // one frame counter, so every marker starts at the same edge
  a_common_edge: assert property ($rose(frame_mark_122ns_high) |-> !frame_mark_31ns_low &&
    !frame_mark_61ns_low && !frame_mark_244ns_low && receive_sync_pulse_out &&
    transmit_sync_pulse_out)
    else $error("markers not aligned");
  // status follows the state one edge after the frame tick
  a_mode_tick: assert property ($changed({normal_status_out, holdover_status_out}) |->
    frame_mark_122ns_high && $past(frame_mark_122ns_high) &&
    !$past(frame_mark_122ns_high, 2))
    else $error("mode changed off the frame tick");
  a_corr_enable: assert property ($rose(phase_step_correct_on) |->
    $rose(frame_mark_122ns_high) ##1 $rose(normal_status_out))
    else $error("correction enabled outside entry to normal");
  a_corr_drop: assert property ($fell(normal_status_out) || $rose(freerun_status_out) |->
    !phase_step_correct_on)
    else $error("correction left on after mode change");
  // lock flag only shown in normal state
  a_lock_gated: assert property (lock_status_out |->
    normal_status_out || $past(normal_status_out))
    else $error("lock flag outside normal");
  c_holdover: cover property ($rose(holdover_status_out));
  c_corr_on: cover property ($rose(phase_step_correct_on));
  c_lock_on: cover property ($rose(lock_status_out));
endmodule

// ---- tb/wtsc_framer_model.sv ----
`timescale 1ns/100ps
`include "wtsc_consts.vh"
// framer side: flags any frame start not one frame after the last
module wtsc_framer_model (
  input wire clk,
  input wire resetn,
  input wire frame_in,
  output reg period_err
);
  reg [15:0] gap_reg; // cycles since last frame start
  reg prev_reg; // marker level last cycle
  reg seen_reg; // first frame has nothing to compare to
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      gap_reg <= 16'h0000;
      prev_reg <= 1'b0;
      seen_reg <= 1'b0;
      period_err <= 1'b0;
    end else begin
      prev_reg <= frame_in;
      if (frame_in && !prev_reg) begin
        if (seen_reg && gap_reg != `WTSC_FRAME_CYC - 1) period_err <= 1'b1;
        gap_reg <= 16'h0000;
        seen_reg <= 1'b1;
      end else begin
        gap_reg <= gap_reg + 16'h0001;
      end
    end
  end
endmodule

// ---- tb/tb.sv ----
`timescale 1ns/100ps
`include "wtsc_consts.vh"
module tb;
  reg clk = 1'b0;
  reg resetn = 1'b0;
  reg rd = 1'b0;
  reg wr = 1'b0;
  reg [3:0] addr = 4'h0;
  reg [31:0] wdata = 32'h00000000;
  reg [1:0] sel = 2'h2; // freerun after reset
  reg en = 1'b0;
  reg quick = 1'b0;
  reg inv = 1'b0;
  reg lock = 1'b1;
  reg cnt_on = 1'b0; // marker width counting window
  reg [31:0] rv; // last read data
  wire [31:0] rdata;
  wire wait_req;
  wire [5:0] mk; // tsp, rsp, 244, 122, 61, 31
  wire [3:0] st; // lock, freerun, holdover, normal
  wire [5:0] act = ~(mk ^ `WTSC_MARK_POL); // marker active levels
  wire corr;
  wire perr;
  integer bad_count = 0;
  integer compares = 0;
  integer i;
  integer j;
  integer w[0:5];
  initial forever #20 clk = ~clk;
  wtsc_state_control #(.LOCK_LIMIT_CYC(32'h000000C8), .FAST_LIMIT_CYC(32'h00000032)) dut_u (
    .clk(clk), .resetn(resetn), .avs_address(addr), .avs_read(rd), .avs_write(wr),
    .avs_byteenable(4'hF), .avs_writedata(wdata), .avs_readdata(rdata),
    .avs_waitrequest(wait_req), .op_select_hi(sel[1]), .op_select_lo(sel[0]),
    .phase_step_correct_enable(en), .quick_acquire_in(quick), .ref_invalid_in(inv),
    .dpll_lock_in(lock), .frame_mark_31ns_low(mk[0]), .frame_mark_61ns_low(mk[1]),
    .frame_mark_122ns_high(mk[2]), .frame_mark_244ns_low(mk[3]),
    .receive_sync_pulse_out(mk[4]), .transmit_sync_pulse_out(mk[5]),
    .normal_status_out(st[0]), .holdover_status_out(st[1]), .freerun_status_out(st[2]),
    .lock_status_out(st[3]), .phase_step_correct_on(corr));
  wtsc_framer_model fm_u (.clk(clk), .resetn(resetn), .frame_in(mk[2]), .period_err(perr));
  // count active cycles of each marker over one frame
  always @(posedge clk) begin
    for (j = 0; j < 6; j = j + 1) if (cnt_on) w[j] <= w[j] + act[j];
  end
  function integer ew(input integer k);
    case (k)
      0: ew = `WTSC_M31_CYC;
      1: ew = `WTSC_M61_CYC;
      2: ew = `WTSC_M122_CYC;
      3: ew = `WTSC_M244_CYC;
      default: ew = `WTSC_M488_CYC;
    endcase
  endfunction
  task report_and_stop;
    if (bad_count == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task chk(input string nm, input [31:0] exp, input [31:0] got);
    compares = compares + 1;
    if (got !== exp) begin
      bad_count = bad_count + 1;
      $display("mismatch %0s exp %h got %h", nm, exp, got);
    end
  endtask
  // one Avalon transfer, held until waitrequest is seen low
  task bus(input w_en, input [3:0] a, input [31:0] d);
    integer n;
    begin
      n = 0;
      @(posedge clk);
      rd <= !w_en;
      wr <= w_en;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      while (wait_req !== 1'b0) begin
        n = n + 1;
        if (n > 20) begin
          bad_count = bad_count + 1;
          report_and_stop;
        end
        @(posedge clk);
      end
      rv = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
    end
  endtask
  // apply pins, let two frames pass, compare state and pins
  task step(input [1:0] s, input bad_ref, input e, input [4:0] ex);
    begin
      @(posedge clk);
      sel <= s;
      inv <= bad_ref;
      en <= e;
      repeat (2 * `WTSC_FRAME_CYC) @(posedge clk);
      bus(1'b0, `WTSC_ADDR_STATUS, 32'h00000000);
      chk("state", {27'h0000000, ex}, rv & 32'h0000001F);
      chk("pins", {27'h0000000, ex[0], ex[3], ex[2] | ex[1], ex[0], ex[4]}, {27'h0, st, corr});
    end
  endtask
  initial begin
    for (i = 0; i < 6; i = i + 1) w[i] = 0;
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    bus(1'b0, `WTSC_ADDR_CTRL, 32'h00000000);
    chk("ctrl", 32'h00000003, rv);
    bus(1'b0, 4'hC, 32'h00000000);
    chk("unmapped", 32'h00000000, rv);
    chk("free", 32'h00000001, st[2]);
    cnt_on <= 1'b1;
    repeat (`WTSC_FRAME_CYC) @(posedge clk);
    cnt_on <= 1'b0;
    @(posedge clk);
    for (i = 0; i < 6; i = i + 1) chk("width", ew(i), w[i]);
    step(2'h0, 1'b0, 1'b1, 5'h01);
    step(2'h1, 1'b0, 1'b1, 5'h04);
    step(2'h0, 1'b0, 1'b1, 5'h11);
    step(2'h3, 1'b0, 1'b0, 5'h11);
    step(2'h0, 1'b1, 1'b0, 5'h02);
    step(2'h0, 1'b0, 1'b1, 5'h11);
    step(2'h2, 1'b0, 1'b1, 5'h08);
    bus(1'b0, `WTSC_ADDR_CHANGES, 32'h00000000);
    chk("changes", 32'h00000006, rv & 32'h0000FFFF);
    chk("period", 32'h00000000, perr);
    // second reset, straight to normal with no lock and quick acquire
    resetn <= 1'b0;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    sel <= 2'h0;
    lock <= 1'b0;
    quick <= 1'b1;
    i = 0;
    while (st[0] !== 1'b1) begin
      i = i + 1;
      if (i > 8000) begin
        bad_count = bad_count + 1;
        report_and_stop;
      end
      @(posedge clk);
    end
    repeat (30) @(posedge clk);
    bus(1'b0, `WTSC_ADDR_STATUS, 32'h00000000);
    chk("early", 32'h00000000, rv[6]);
    chk("nolock", 32'h00000000, st[3]);
    repeat (40) @(posedge clk);
    bus(1'b0, `WTSC_ADDR_STATUS, 32'h00000000);
    chk("late", 32'h00000001, rv[6]);
    lock <= 1'b1;
    repeat (4) @(posedge clk);
    bus(1'b1, `WTSC_ADDR_STATUS, 32'h00000040);
    bus(1'b0, `WTSC_ADDR_STATUS, 32'h00000000);
    chk("cleared", 32'h00000000, rv[6]);
    chk("locked", 32'h00000001, st[3]);
    report_and_stop;
  end
endmodule
bind wtsc_state_control wtsc_properties chk_u (.clk(clk), .resetn(resetn),
  .frame_mark_31ns_low(frame_mark_31ns_low), .frame_mark_61ns_low(frame_mark_61ns_low),
  .frame_mark_122ns_high(frame_mark_122ns_high), .frame_mark_244ns_low(frame_mark_244ns_low),
  .receive_sync_pulse_out(receive_sync_pulse_out),
  .transmit_sync_pulse_out(transmit_sync_pulse_out), .normal_status_out(normal_status_out),
  .holdover_status_out(holdover_status_out), .freerun_status_out(freerun_status_out),
  .lock_status_out(lock_status_out), .phase_step_correct_on(phase_step_correct_on));
